// File: include/jtag_pkg.sv
// Shared constants and types for the test access port and its scan chain.
// Assumes a single core clock domain; test pins arrive asynchronously.
`default_nettype none

package jtag_pkg;

   // Pin and cell counts
   localparam int NUM_IO = 68;
   localparam int NUM_IN = 4;
   localparam int NUM_PINS = NUM_IO + NUM_IN;
   localparam int NUM_MC = 64;
   localparam int NUM_CELLS = NUM_PINS + NUM_MC;
   localparam int IO_STAGES = 3;
   localparam int IO_UPDATES = 2;
   localparam int MC_STAGES = 1;
   localparam int MC_UPDATES = 0;

   // Test pin positions within the four-pin group
   localparam int PIN_TDI = 0;
   localparam int PIN_TMS = 1;
   localparam int PIN_TCK = 2;
   localparam int PIN_TDO = 3;

   // Instruction register
   localparam int IR_LEN = 4;
   localparam int ID_LEN = 32;
   localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
   localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h2;
   localparam logic [IR_LEN-1:0] IR_HIGHZ = 4'h3;
   localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hf;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

   // Consecutive high-TMS rising edges that always reach reset
   localparam logic [2:0] TMS_RESET_RISES = 3'h5;

   // Register map (byte addresses)
   localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFF_STATUS = 32'h0000_0004;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PU_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int STAT_IR_LSB = 4;

   // Controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;

   // Wishbone request and answer
   typedef struct packed {
      logic [31:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic cyc;
      logic stb;
   } wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // Scan cell strobes, one core cycle each
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
   } scan_ctl_t;

endpackage

`default_nettype wire

// File: src/tap_fsm.sv
// Sixteen-state test access port controller.
// Assumes tck_rise is a one-cycle core-clock pulse and tms is synchronised.
`default_nettype none

module tap_fsm
   import jtag_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic hold_reset,
   input wire logic tck_rise,
   input wire logic tms,
   output tap_state_t state
);

   tap_state_t next_state;
   logic [2:0] ones_cnt;
   logic [2:0] next_ones_cnt;

   // Next state on each test clock rising edge
   always_comb begin
      next_state = state;
      next_ones_cnt = ones_cnt;
      if (hold_reset) begin
         next_state = TLR;
         next_ones_cnt = 3'h0;
      end else if (tck_rise) begin
         if (!tms) begin
            next_ones_cnt = 3'h0;
         end else if (ones_cnt != TMS_RESET_RISES) begin
            next_ones_cnt = ones_cnt + 3'h1;
         end
         unique case (state)
            TLR: next_state = tms ? TLR : RTI;
            RTI: next_state = tms ? SEL_DR : RTI;
            SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tms ? EX1_DR : SH_DR;
            SH_DR: next_state = tms ? EX1_DR : SH_DR;
            EX1_DR: next_state = tms ? UPD_DR : PA_DR;
            PA_DR: next_state = tms ? EX2_DR : PA_DR;
            EX2_DR: next_state = tms ? UPD_DR : SH_DR;
            UPD_DR: next_state = tms ? SEL_DR : RTI;
            SEL_IR: next_state = tms ? TLR : CAP_IR;
            CAP_IR: next_state = tms ? EX1_IR : SH_IR;
            SH_IR: next_state = tms ? EX1_IR : SH_IR;
            EX1_IR: next_state = tms ? UPD_IR : PA_IR;
            PA_IR: next_state = tms ? EX2_IR : PA_IR;
            EX2_IR: next_state = tms ? UPD_IR : SH_IR;
            UPD_IR: next_state = tms ? SEL_DR : RTI;
         endcase
      end
   end

   // Power-up reset forces the reset state
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TLR;
         ones_cnt <= 3'h0;
      end else begin
         state <= next_state;
         ones_cnt <= next_ones_cnt;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_tms_five_reset:
   assert property (ones_cnt == TMS_RESET_RISES |-> state == TLR)
      else $error("five high TMS edges did not reach reset");

   a_hold_reset:
   assert property (hold_reset |=> state == TLR)
      else $error("held controller left reset");

endmodule

`default_nettype wire

// File: src/scan_cell.sv
// Boundary scan cell: capture/shift stages and optional update stages.
// Assumes strobes in ctl are mutually exclusive core-clock pulses.
`default_nettype none

module scan_cell
   import jtag_pkg::*;
#(
   parameter int STAGES = IO_STAGES,
   parameter int UPDATES = IO_UPDATES
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire scan_ctl_t ctl,
   input wire logic scan_in,
   input wire logic [STAGES-1:0] func,
   output logic scan_out,
   output logic [1:0] upd
);

   logic [STAGES-1:0] stage;
   logic [STAGES-1:0] next_stage;
   logic [STAGES:0] link;

   assign link = {stage, scan_in};
   assign scan_out = stage[STAGES-1];

   // Capture live signals or shift one place toward scan_out
   always_comb begin
      next_stage = stage;
      if (ctl.capture) begin
         next_stage = func;
      end else if (ctl.shift) begin
         next_stage = link[STAGES-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage <= '0;
      end else begin
         stage <= next_stage;
      end
   end

   // I/O pin cells hold output data and enable; input pin and macrocell cells hold none
   if (UPDATES > 0) begin : g_upd
      logic [1:0] next_upd;
      always_comb begin
         next_upd = upd;
         if (ctl.update) begin
            next_upd = stage[2:1];
         end
      end
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            upd <= '0;
         end else begin
            upd <= next_upd;
         end
      end
   end else begin : g_no_upd
      assign upd = 2'h0;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_cell_capture:
   assert property (ctl.capture |=> stage == $past(func))
      else $error("capture stage missed live value");

   a_cell_shift:
   assert property (ctl.shift && !ctl.capture |=> stage[0] == $past(scan_in))
      else $error("shift did not take serial input");

endmodule

`default_nettype wire

// File: src/jtag_boundary_scan_isp_port.sv
// Test access port with boundary scan chain and Wishbone control registers.
// Assumes test pins are asynchronous to core_clk and run far slower.
//
// Summary of operation
// - No test-reset pin; the controller resets at power-up.
// - Instructions are sample/preload, extest, bypass, idcode and highz only.
// - Each dedicated input and each I/O pin owns a boundary scan cell.
// - When the test port is disabled its four pins are plain user I/O.
// - Cells chain through capture stages from TDI to TDO.
// - Capture stages sample live signals, shift, and feed the update stages.
// - Capture, shift and update strobes come from the controller inside.
// - A cell has up to three capture stages and two update stages.
// - Pin cells and macrocell cells are two separate variants.
// - TMS and TDI pull-ups are a configuration option.
// - Programming uses the same four pins and standard serial protocol.
`default_nettype none

module jtag_boundary_scan_isp_port
   import jtag_pkg::*;
#(
   parameter logic [ID_LEN-1:0] ID_VALUE = 32'h0000_0001 // arbitrary identity value
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire wb_req_t wb_req,
   output wb_rsp_t wb_rsp,
   input wire logic [3:0] jtag_pin_in,
   output logic [3:0] jtag_pin_out,
   output logic [3:0] jtag_pin_oe,
   output logic pullup_en,
   output logic [3:0] user_jtag_in,
   input wire logic [3:0] user_jtag_out,
   input wire logic [3:0] user_jtag_oe,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_IO-1:0] core_out,
   input wire logic [NUM_IO-1:0] core_oe,
   input wire logic [NUM_MC-1:0] mc_out,
   output logic [NUM_IO-1:0] io_out,
   output logic [NUM_IO-1:0] io_oe
);

   // Instruction decodes shared by several groups
   function automatic logic sel_bscan(input logic [IR_LEN-1:0] code);
      sel_bscan = (code == IR_EXTEST) || (code == IR_SAMPLE);
   endfunction

   function automatic logic sel_bypass(input logic [IR_LEN-1:0] code);
      sel_bypass = !sel_bscan(code) && (code != IR_IDCODE);
   endfunction

   function automatic logic addr_is(input logic [31:0] adr, input logic [31:0] off);
      addr_is = (adr == off);
   endfunction

   logic [3:0] jp_s1, jp_s2;
   logic tck_d;
   logic [NUM_PINS-1:0] pin_s1, pin_s2;
   logic [1:0] ctrl, next_ctrl;
   wb_rsp_t next_wb_rsp;
   tap_state_t state;
   logic [IR_LEN-1:0] ir, next_ir, ir_shift, next_ir_shift;
   logic [ID_LEN-1:0] id_shift, next_id_shift;
   logic bypass_bit, next_bypass_bit;
   logic tdo, next_tdo, tdo_oe, next_tdo_oe;
   logic [3:0] next_jp_out, next_jp_oe;
   logic [NUM_IO-1:0] next_io_out, next_io_oe, upd_out, upd_oe;
   logic [NUM_CELLS:0] link;
   scan_ctl_t scan_ctl;
   logic en, tck_s, tms_s, tdi_s, tck_rise, tck_fall, dr_bscan;

   // Two-flop synchronisers for all pins, plus a TCK edge tap
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         jp_s1 <= 4'h0;
         jp_s2 <= 4'h0;
         tck_d <= 1'b0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         jp_s1 <= jtag_pin_in;
         jp_s2 <= jp_s1;
         tck_d <= jp_s2[PIN_TCK];
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // Synchronised pin levels and TCK edge events
   assign en = ctrl[CTRL_EN_BIT];
   assign tck_s = jp_s2[PIN_TCK];
   assign tms_s = jp_s2[PIN_TMS];
   assign tdi_s = jp_s2[PIN_TDI];
   assign tck_rise = en && tck_s && !tck_d;
   assign tck_fall = en && !tck_s && tck_d;
   assign user_jtag_in = jp_s2;
   assign pullup_en = ctrl[CTRL_PU_BIT];

   // Controller; held in reset while the port is disabled
   tap_fsm u_tap (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .hold_reset(!en),
      .tck_rise(tck_rise),
      .tms(tms_s),
      .state(state)
   );

   // Scan strobes generated from controller state
   assign dr_bscan = sel_bscan(ir);
   assign scan_ctl.capture = tck_rise && (state == CAP_DR) && dr_bscan;
   assign scan_ctl.shift = tck_rise && (state == SH_DR) && dr_bscan;
   assign scan_ctl.update = tck_fall && (state == UPD_DR) && dr_bscan;

   // Chain: TDI feeds the first pin cell, last macrocell cell feeds TDO
   assign link[0] = tdi_s;
   for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
      if (k < NUM_IO) begin : g_io
         scan_cell #(.STAGES(IO_STAGES), .UPDATES(IO_UPDATES)) u_cell (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .ctl(scan_ctl),
            .scan_in(link[k]),
            .func({core_oe[k], core_out[k], pin_s2[k]}),
            .scan_out(link[k+1]),
            .upd({upd_oe[k], upd_out[k]})
         );
      end else begin : g_in
         scan_cell #(.STAGES(IO_STAGES), .UPDATES(MC_UPDATES)) u_cell (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .ctl(scan_ctl),
            .scan_in(link[k]),
            .func({2'h0, pin_s2[k]}),
            .scan_out(link[k+1]),
            .upd()
         );
      end
   end
   for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
      scan_cell #(.STAGES(MC_STAGES), .UPDATES(MC_UPDATES)) u_cell (
         .core_clk(core_clk),
         .arst_n(arst_n),
         .ctl(scan_ctl),
         .scan_in(link[NUM_PINS+m]),
         .func(mc_out[m]),
         .scan_out(link[NUM_PINS+m+1]),
         .upd()
      );
   end

   // Instruction, identity, bypass and TDO next values
   always_comb begin
      next_ir = ir;
      next_ir_shift = ir_shift;
      next_id_shift = id_shift;
      next_bypass_bit = bypass_bit;
      next_tdo = tdo;
      next_tdo_oe = tdo_oe;
      if (state == TLR) begin
         next_ir = IR_IDCODE;
      end
      if (tck_rise) begin
         if (state == CAP_IR) begin
            next_ir_shift = IR_CAPTURE;
         end else if (state == SH_IR) begin
            next_ir_shift = {tdi_s, ir_shift[IR_LEN-1:1]};
         end
         if (state == CAP_DR) begin
            next_id_shift = ID_VALUE;
            next_bypass_bit = 1'b0;
         end else if (state == SH_DR) begin
            next_id_shift = {tdi_s, id_shift[ID_LEN-1:1]};
            next_bypass_bit = tdi_s;
         end
      end
      if (tck_fall) begin
         if (state == UPD_IR) begin
            next_ir = ir_shift;
         end
         next_tdo_oe = (state == SH_DR) || (state == SH_IR);
         if (state == SH_IR) begin
            next_tdo = ir_shift[0];
         end else if (state == SH_DR) begin
            if (dr_bscan) begin
               next_tdo = link[NUM_CELLS];
            end else if (sel_bypass(ir)) begin
               next_tdo = bypass_bit;
            end else begin
               next_tdo = id_shift[0];
            end
         end
      end
      if (!en) begin
         next_tdo_oe = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ir <= IR_IDCODE;
         ir_shift <= '0;
         id_shift <= '0;
         bypass_bit <= 1'b0;
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         ir <= next_ir;
         ir_shift <= next_ir_shift;
         id_shift <= next_id_shift;
         bypass_bit <= next_bypass_bit;
         tdo <= next_tdo;
         tdo_oe <= next_tdo_oe;
      end
   end

   // Test pins or user I/O, and pin drive under test modes
   always_comb begin
      next_jp_out = user_jtag_out;
      next_jp_oe = user_jtag_oe;
      if (en) begin
         next_jp_out = 4'h0;
         next_jp_oe = 4'h0;
         next_jp_out[PIN_TDO] = tdo;
         next_jp_oe[PIN_TDO] = tdo_oe;
      end
      next_io_out = core_out;
      next_io_oe = core_oe;
      if (ir == IR_EXTEST) begin
         next_io_out = upd_out;
         next_io_oe = upd_oe;
      end else if (ir == IR_HIGHZ) begin
         next_io_oe = '0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         jtag_pin_out <= 4'h0;
         jtag_pin_oe <= 4'h0;
         io_out <= '0;
         io_oe <= '0;
      end else begin
         jtag_pin_out <= next_jp_out;
         jtag_pin_oe <= next_jp_oe;
         io_out <= next_io_out;
         io_oe <= next_io_oe;
      end
   end

   // Wishbone slave: ack one cycle after request, write at the ack edge
   always_comb begin
      next_ctrl = ctrl;
      next_wb_rsp.ack = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
      next_wb_rsp.dat = wb_rsp.dat;
      if (wb_req.cyc && wb_req.stb && wb_rsp.ack && wb_req.we && wb_req.sel[0]) begin
         if (addr_is(wb_req.adr, OFF_CTRL)) begin
            next_ctrl = wb_req.dat[1:0];
         end
      end
      if (next_wb_rsp.ack) begin
         if (addr_is(wb_req.adr, OFF_CTRL)) begin
            next_wb_rsp.dat = {30'h0, ctrl};
         end else if (addr_is(wb_req.adr, OFF_STATUS)) begin
            next_wb_rsp.dat = {24'h0, ir, 4'(state)};
         end else begin
            next_wb_rsp.dat = 32'h0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RESET;
         wb_rsp <= '0;
      end else begin
         ctrl <= next_ctrl;
         wb_rsp <= next_wb_rsp;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_dr_capture;
      tck_rise && (state == CAP_DR);
   endsequence

   sequence s_shift_fall;
      tck_fall && (state == SH_DR);
   endsequence

   a_bypass_zero:
   assert property ((s_dr_capture ##0 sel_bypass(ir)) |=> bypass_bit == 1'b0)
      else $error("bypass bit did not capture zero");

   a_bypass_tdo:
   assert property ((s_shift_fall ##0 sel_bypass(ir)) |=> tdo == $past(bypass_bit) && tdo_oe)
      else $error("bypass bit not presented on TDO");

   a_id_capture:
   assert property ((s_dr_capture ##0 ir == IR_IDCODE) |=> id_shift == ID_VALUE)
      else $error("identity not loaded at capture");

   a_ir_capture:
   assert property (tck_rise && state == CAP_IR |=> ir_shift == IR_CAPTURE)
      else $error("instruction capture pattern wrong");

   a_tdo_quiet:
   assert property (tck_fall && state != SH_DR && state != SH_IR |=> !tdo_oe)
      else $error("TDO driven outside shifting");

   a_user_pins:
   assert property (!en |=> jtag_pin_out == $past(user_jtag_out) && state == TLR)
      else $error("disabled port did not pass user I/O");

   a_tdo_pin:
   assert property (en && $past(en) && tdo_oe |=> jtag_pin_oe[PIN_TDO] ##1 1'b1)
      else $error("TDO pin not enabled while shifting");

   a_highz_pins:
   assert property (ir == IR_HIGHZ |=> io_oe == '0)
      else $error("pins driven under highz");

   a_extest_drive:
   assert property (ir == IR_EXTEST |=> io_out == $past(upd_out) && io_oe == $past(upd_oe))
      else $error("extest did not drive update values");

endmodule

`default_nettype wire

// File: dv/jtag_tester.sv
// Tester model for the test port: drives TCK, TMS and TDI, reads TDO.
// Assumes core_clk is the bench clock; one TCK period is 16 core cycles.
`default_nettype none
module jtag_tester (
   input wire logic core_clk,
   input wire logic tdo_out,
   input wire logic tdo_oe,
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic tdo_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last = 1'b0;
   // Released TDO line shows the inverse of its last driven level
   always @(posedge core_clk) if (tdo_oe) last <= tdo_out;
   assign tdo_seen = tdo_oe ? tdo_out : ~last;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One TCK period: fall with new TMS and TDI, sample TDO, rise
   task automatic step(input logic m, input logic d, output logic t);
      @(posedge core_clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (8) @(posedge core_clk);
      t = tdo_seen;
      tck <= 1'b1;
      repeat (7) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the test port: Wishbone tasks and tester scans.
// Assumes the tester model drives the test pins the DUT leaves undriven.
`default_nettype none
module tb
   import jtag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CH = NUM_PINS * IO_STAGES + NUM_MC * MC_STAGES;
   logic core_clk = 1'b0;
   logic arst_n;
   wb_req_t wb_req;
   wb_rsp_t wb_rsp;
   logic [3:0] jtag_pin_in, jtag_pin_out, jtag_pin_oe, user_jtag_in, user_jtag_out, user_jtag_oe;
   logic pullup_en, tck, tms, tdi, tdo_seen;
   logic [NUM_PINS-1:0] pin_in;
   logic [NUM_IO-1:0] core_out, core_oe, io_out, io_oe;
   logic [NUM_MC-1:0] mc_out;
   logic [31:0] rd;
   logic [CH-1:0] dv, exp_chain, pre;
   // Last entry is an undefined code, which must act as bypass
   logic [IR_LEN-1:0] codes [6] = '{IR_EXTEST, IR_SAMPLE, IR_IDCODE, IR_HIGHZ, IR_BYPASS, 4'h7};
   logic v;
   int num_errors = 0;
   int n_compared = 0;
   always #2 core_clk = ~core_clk;
   // Wire level of each test pin from both drivers
   assign jtag_pin_in = (jtag_pin_oe & jtag_pin_out) | (~jtag_pin_oe & {tdo_seen, tck, tms, tdi});
   jtag_boundary_scan_isp_port i_dut (.core_clk(core_clk), .arst_n(arst_n), .wb_req(wb_req),
      .wb_rsp(wb_rsp), .jtag_pin_in(jtag_pin_in), .jtag_pin_out(jtag_pin_out),
      .jtag_pin_oe(jtag_pin_oe), .pullup_en(pullup_en), .user_jtag_in(user_jtag_in),
      .user_jtag_out(user_jtag_out), .user_jtag_oe(user_jtag_oe), .pin_in(pin_in),
      .core_out(core_out), .core_oe(core_oe), .mc_out(mc_out), .io_out(io_out), .io_oe(io_oe));
   jtag_tester jt (.core_clk(core_clk), .tdo_out(jtag_pin_out[3]), .tdo_oe(jtag_pin_oe[3]),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo_seen(tdo_seen));
   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [CH-1:0] got, input logic [CH-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat,
      input logic [3:0] sel);
      @(posedge core_clk);
      wb_req <= {adr, dat, sel, we, 2'b11};
      // No answer time assumed; only the watchdog ends a wait
      do begin
         @(posedge core_clk);
      end while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
   endtask
   // Five high TMS rises reach reset, then idle
   task automatic tap_reset;
      repeat (5) jt.step(1'b1, 1'b0, v);
      jt.step(1'b0, 1'b0, v);
   endtask
   // From idle: one IR or DR scan of n bits, back to idle
   task automatic scan(input bit ir, input int n, input logic [CH-1:0] din);
      jt.step(1'b1, 1'b0, v);
      if (ir) jt.step(1'b1, 1'b0, v);
      jt.step(1'b0, 1'b0, v);
      jt.step(1'b0, 1'b0, v);
      dv = '0;
      for (int k = 0; k < n; k++) begin
         jt.step(k == n - 1, din[k], v);
         dv[k] = v;
      end
      jt.step(1'b1, 1'b0, v);
      jt.step(1'b0, 1'b0, v);
   endtask
   // Main sequence
   initial begin
      arst_n = 1'b0;
      wb_req = '0;
      pin_in = {18{4'hc}};
      core_out = {17{4'h9}};
      core_oe = {17{4'h3}};
      mc_out = {16{4'h6}};
      user_jtag_out = 4'ha;
      user_jtag_oe = 4'hf;
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      wb(1'b0, 32'h0, 32'h0, 4'hf);
      chk(rd, 32'h3);
      chk(pullup_en, 1'b1);
      wb(1'b0, 32'h4, 32'h0, 4'hf);
      chk(rd[7:0], {IR_IDCODE, 4'h0});
      wb(1'b1, 32'h8, 32'hffff_ffff, 4'hf);
      wb(1'b0, 32'h8, 32'h0, 4'hf);
      chk(rd, 32'h0);
      tap_reset;
      scan(1'b0, ID_LEN, '0);
      chk(dv[ID_LEN-1:0], 32'h1);
      chk(jtag_pin_oe[3], 1'b0);
      for (int i = 0; i < 6; i++) begin
         scan(1'b1, IR_LEN, codes[i]);
         chk(dv[IR_LEN-1:0], IR_CAPTURE);
         wb(1'b0, 32'h4, 32'h0, 4'hf);
         chk(rd[7:0], {codes[i], 4'h1});
         if (codes[i] == IR_HIGHZ) chk(io_oe, '0);
         // Highz, bypass and undefined codes all select the one-bit path
         if (i >= 3) begin
            scan(1'b0, 4, 4'ha);
            chk(dv[3:0], 4'h4);
         end
      end
      scan(1'b0, 4, 4'ha);
      chk(dv[3:0], 4'h4);
      chk(io_out, core_out);
      // Chain image and preload pattern by chain position from TDI
      for (int p = 0; p < CH; p++) begin
         if (p >= NUM_PINS * IO_STAGES) exp_chain[CH-1-p] = mc_out[p - NUM_PINS * IO_STAGES];
         else if (p % 3 == 0) exp_chain[CH-1-p] = pin_in[p / 3];
         else if (p / 3 >= NUM_IO) exp_chain[CH-1-p] = 1'b0;
         else exp_chain[CH-1-p] = (p % 3 == 1) ? core_out[p / 3] : core_oe[p / 3];
         pre[CH-1-p] = (p % 3 == 2) || (p % 3 == 1 && (p / 3) % 2 == 0);
      end
      scan(1'b1, IR_LEN, IR_SAMPLE);
      scan(1'b0, CH, pre);
      chk(dv, exp_chain);
      scan(1'b1, IR_LEN, IR_EXTEST);
      repeat (4) @(posedge core_clk);
      chk(io_out, {34{2'b01}});
      chk(io_oe, {NUM_IO{1'b1}});
      wb(1'b1, 32'h0, 32'h0, 4'hf);
      repeat (4) @(posedge core_clk);
      chk(pullup_en, 1'b0);
      chk(jtag_pin_out, 4'ha);
      chk(user_jtag_in, 4'ha);
      user_jtag_oe <= 4'h8;
      repeat (3) jt.step(1'b0, 1'b0, v);
      chk(jtag_pin_oe, 4'h8);
      wb(1'b0, 32'h4, 32'h0, 4'hf);
      chk(rd[3:0], 4'h0);
      wb(1'b1, 32'h0, 32'h1, 4'h0);
      wb(1'b0, 32'h0, 32'h0, 4'hf);
      chk(rd, 32'h0);
      conclude;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      conclude;
   end
endmodule
`default_nettype wire
